// ---- hmmd_checker.sv ----
// Concurrent checks on the host memory decoder ports.
// Assumes it is bound to hmmd_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module hmmd_checker (
  input wire logic                clk_sys,
  input wire logic                nrst,
  input wire logic                rom_64k,
  input wire logic                mem_req,
  input wire logic [19:0]         mem_addr,
  input wire hmmd_pkg::hmmd_mem_t mem_dec,
  input wire logic                io_rd,
  input wire logic                io_wr,
  input wire logic [15:0]         io_addr,
  input wire logic [15:0]         io_wdata,
  input wire logic                fifo_irq,
  input wire logic                ps_we,
  input wire logic [15:0]         ps_wdata
);
  // ======================================
  // Properties
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_DRAM: assert property (mem_req && !mem_addr[19] |=>
    mem_dec.sel == hmmd_pkg::HMMD_SEL_DRAM && mem_dec.ready) else $error("dram decode");
  AST_ROM: assert property (mem_req && mem_addr[19:15] == 5'h1f |=>
    mem_dec.sel == hmmd_pkg::HMMD_SEL_ROM && mem_dec.ready) else $error("rom decode");
  AST_ROM_HALF: assert property (mem_req && !rom_64k && mem_addr[19:15] == 5'h1e |=>
    mem_dec.sel != hmmd_pkg::HMMD_SEL_ROM) else $error("rom lower half selected");
  AST_WIN: assert property (mem_req && mem_addr[19:18] == 2'h2 |=>
    mem_dec.sel == hmmd_pkg::HMMD_SEL_PAGE && mem_dec.ready) else $error("window decode");
  AST_GAP: assert property (mem_req && mem_addr[19:17] == 3'h6 |=>
    mem_dec.sel == hmmd_pkg::HMMD_SEL_NONE && !mem_dec.ready) else $error("gap selected");
  AST_SRAM: assert property (mem_req && mem_addr[19:16] == 4'he |=>
    mem_dec.sel == hmmd_pkg::HMMD_SEL_SRAM) else $error("sram decode");
  AST_SRAM_DONE: assert property ($rose(mem_req) && mem_addr[19:16] == 4'he |->
    ##[1:16] mem_dec.ready) else $error("sram cycle not completed");
  AST_IRQ: assert property (fifo_irq && !io_rd && !$past(io_rd) && !$past(io_rd, 2)
    |=> fifo_irq) else $error("irq dropped without a read");
  AST_PS: assert property (io_wr && io_addr == 16'h22c0 |=>
    ps_we && ps_wdata == $past(io_wdata)) else $error("program ram write");

  // Main scenarios reached.
  cover property (mem_dec.sel == hmmd_pkg::HMMD_SEL_PAGE);
  cover property (fifo_irq ##1 !fifo_irq);
  cover property (ps_we);
endmodule

bind hmmd_top hmmd_checker u_chk (.clk_sys, .nrst, .rom_64k, .mem_req, .mem_addr, .mem_dec,
  .io_rd, .io_wr, .io_addr, .io_wdata, .fifo_irq, .ps_we, .ps_wdata);

`default_nettype wire

// ---- hmmd_defs.svh ----
// Address map constants, I/O port addresses and field positions for the host
// memory map decoder. Assumes a 20-bit host memory address and 16-bit I/O addresses.
`ifndef HMMD_DEFS_SVH
`define HMMD_DEFS_SVH

// ==========================================================================
// Memory map
// ==========================================================================
`define HMMD_ROM_BASE      20'hf0000
`define HMMD_ROM_HALF      20'hf8000
`define HMMD_SRAM_BASE     20'he0000
`define HMMD_WIN_LO_BASE   20'h80000
`define HMMD_WIN_HI_BASE   20'ha0000
`define HMMD_WIN_END       20'hbffff
`define HMMD_DRAM_END      20'h7ffff
`define HMMD_SRAM_AW       13
`define HMMD_PAGE_W        5
`define HMMD_PAGE_MAX_BASE 5'h0f
`define HMMD_PAGE_MAX_EXP  5'h17

// ==========================================================================
// I/O map
// ==========================================================================
`define HMMD_IO_PAGE       16'h2220
`define HMMD_IO_CLRPANEL   16'h2240
`define HMMD_IO_SWITCHES   16'h2248
`define HMMD_IO_FIFO       16'h22c0
`define HMMD_IO_PSRAM      16'h22b0
`define HMMD_PAGE_HI_LSB   8
`define HMMD_FIFO_DEPTH    64
`define HMMD_PSRAM_AW      12

`endif

// ---- hmmd_host_bfm.sv ----
// Host processor bus model: byte memory cycles and I/O port cycles.
// Assumes the bench calls its tasks; pins change just after clk_sys edges.
`timescale 1ns/1ps
`default_nettype none

module hmmd_host_bfm (
  input  wire logic                clk_sys,
  input  wire hmmd_pkg::hmmd_mem_t mem_dec,
  input  wire logic [15:0]         io_rdata,
  output var  logic                mem_req,
  output var  logic                mem_we,
  output var  logic                mem_word,
  output var  logic [19:0]         mem_addr,
  output var  logic [7:0]          mem_wdata,
  output var  logic                io_rd,
  output var  logic                io_wr,
  output var  logic [15:0]         io_addr,
  output var  logic [15:0]         io_wdata
);
  // ======================================
  // Bus cycles
  // Idle levels; the model only ever issues byte cycles.
  initial begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_word  = 1'b0;
    mem_addr  = 20'h00000;
    mem_wdata = 8'h00;
    io_rd     = 1'b0;
    io_wr     = 1'b0;
    io_addr   = 16'h0000;
    io_wdata  = 16'h0000;
  end

  // Holds the request until ready, or gives up as the watchdog would.
  task automatic mem_cycle(input logic [19:0] a, input logic we, input logic [7:0] d,
                           output hmmd_pkg::hmmd_mem_t r);
    int i;
    @(posedge clk_sys);
    mem_req   <= 1'b1;
    mem_we    <= we;
    mem_addr  <= a;
    mem_wdata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      r = mem_dec;
      if (i > 0 && r.ready === 1'b1) break;
    end
    mem_req   <= 1'b0;
    mem_addr  <= ~a; // Released lines do not keep the old address.
    mem_wdata <= ~d;
  endtask

  // Single-cycle port write strobe.
  task automatic io_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    io_wr    <= 1'b1;
    io_addr  <= a;
    io_wdata <= d;
    @(posedge clk_sys);
    io_wr    <= 1'b0;
    io_wdata <= ~d;
  endtask

  // Single-cycle port read strobe; data is taken one cycle later.
  task automatic io_read(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    io_rd   <= 1'b1;
    io_addr <= a;
    @(posedge clk_sys);
    io_rd   <= 1'b0;
    @(posedge clk_sys);
    d = io_rdata;
  endtask
endmodule

`default_nettype wire

// ---- hmmd_pkg.sv ----
// Types shared by the host memory map decoder and its memories.
// Assumes hmmd_defs.svh is compiled alongside.
package hmmd_pkg;

  // ==========================================================================
  // Memory selects
  // ==========================================================================
  typedef enum logic [2:0] {
    HMMD_SEL_NONE = 3'h0,
    HMMD_SEL_DRAM = 3'h1,
    HMMD_SEL_PAGE = 3'h3,
    HMMD_SEL_SRAM = 3'h2,
    HMMD_SEL_ROM  = 3'h6
  } hmmd_sel_t;

  // Decoded memory strobe bundle.
  typedef struct packed {
    hmmd_sel_t   sel;
    logic [20:0] addr;
    logic        ready;
  } hmmd_mem_t;

endpackage

// ---- hmmd_ram.sv ----
// Single memory used for the byte FIFO storage and the shared SRAM.
// Assumes one clock; write and read ports registered.
`timescale 1ns/1ps
`default_nettype none

module hmmd_ram #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [DW-1:0] mem [2**AW];

  initial begin
    if (AW < 1 || DW < 1) begin
      $error("hmmd_ram: bad size");
    end
  end

  // Write and registered read.
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// ---- hmmd_shared.sv ----
// Dual-ported shared SRAM with alternating-priority arbitration between host and
// slave line processor. Assumes byte-wide requests held until granted.
`timescale 1ns/1ps
`default_nettype none

module hmmd_shared #(
  parameter int AW = 13
) (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          h_req,
  input  wire logic          h_we,
  input  wire logic [AW-1:0] h_addr,
  input  wire logic [7:0]    h_wdata,
  output var  logic          h_ack,
  input  wire logic          s_req,
  input  wire logic          s_we,
  input  wire logic [AW-1:0] s_addr,
  input  wire logic [7:0]    s_wdata,
  output var  logic          s_ack,
  output var  logic [7:0]    rdata
);

  // ==========================================================================
  // Arbiter: alternates priority so neither side starves
  // ==========================================================================
  logic          last_h_r;
  logic          last_h_nxt;
  logic          h_ack_nxt;
  logic          s_ack_nxt;
  logic          g_h;
  logic          g_s;
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wd;

  // Grant one side per cycle; round robin on conflict.
  always_comb begin
    g_h = h_req && !h_ack && (!s_req || s_ack || !last_h_r);
    g_s = s_req && !s_ack && !g_h;
    last_h_nxt = g_h ? 1'b1 : (g_s ? 1'b0 : last_h_r);
    h_ack_nxt = g_h;
    s_ack_nxt = g_s;
    we   = g_h ? h_we : (g_s && s_we);
    addr = g_h ? h_addr : s_addr;
    wd   = g_h ? h_wdata : s_wdata;
  end

  // Register grant state.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      last_h_r <= 1'b0;
      h_ack    <= 1'b0;
      s_ack    <= 1'b0;
    end else begin
      last_h_r <= last_h_nxt;
      h_ack    <= h_ack_nxt;
      s_ack    <= s_ack_nxt;
    end
  end

  // Byte-wide storage.
  hmmd_ram #(.AW(AW), .DW(8)) u_mem (
    .clk_sys (clk_sys),
    .we      (we),
    .waddr   (addr),
    .wdata   (wd),
    .raddr   (addr),
    .rdata   (rdata)
  );

endmodule

`default_nettype wire

// ---- hmmd_top.sv ----
// Host memory map decoder: memory selects, page windows, slave FIFO,
// panel switch latches and slave program RAM load port.
// Assumes a host bus synchronous to clk_sys; panel switches asynchronous.
// Function
// - Top 64K selects boot ROM.
// - 32K ROM answers only upper half.
// - Lowest 512K selects DRAM, zero waits.
// - Shared SRAM linear from base address.
// - Shared SRAM byte accesses only.
// - Space above SRAM aliases onto it.
// - Alias accesses complete, no watchdog timeout.
// - Paged RAM 1M, 1.5M with expansion.
// - Two 128K windows, 64K steps.
// - Low and high window address ranges.
// - Window accesses zero wait states.
// - Shared SRAM arbitrated host and slave.
// - 64x8 FIFO from slave to host.
// - Interrupt held while FIFO not empty.
// - Four switch latches, cleared by program.
// - Host loads slave program RAM.
// - Page register has two 5-bit fields.
// - Window bottom at 64K times page.
`timescale 1ns/1ps
`default_nettype none
`include "hmmd_defs.svh"

module hmmd_top #(
  parameter int FIFO_AW = 6,
  parameter int PS_AW   = `HMMD_PSRAM_AW
) (
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    rom_64k,
  input  wire logic                    ram_exp,
  input  wire logic                    mem_req,
  input  wire logic                    mem_we,
  input  wire logic                    mem_word,
  input  wire logic [19:0]             mem_addr,
  input  wire logic [7:0]              mem_wdata,
  output var  hmmd_pkg::hmmd_mem_t     mem_dec,
  output var  logic [7:0]              sram_rdata,
  input  wire logic                    io_rd,
  input  wire logic                    io_wr,
  input  wire logic [15:0]             io_addr,
  input  wire logic [15:0]             io_wdata,
  output var  logic [15:0]             io_rdata,
  output var  logic                    fifo_irq,
  input  wire logic                    slp_fifo_wr,
  input  wire logic [7:0]              slp_fifo_data,
  output var  logic                    slp_fifo_full,
  input  wire logic                    slp_sram_req,
  input  wire logic                    slp_sram_we,
  input  wire logic [12:0]             slp_sram_addr,
  input  wire logic [7:0]              slp_sram_wdata,
  output var  logic                    slp_sram_ack,
  output var  logic                    ps_we,
  output var  logic [PS_AW-1:0]        ps_addr,
  output var  logic [15:0]             ps_wdata,
  input  wire logic [3:0]              panel_sw
);

  initial begin
    if (FIFO_AW != 6 || PS_AW < 1) begin
      $error("hmmd_top: FIFO must be 64 deep");
    end
  end

  // ==========================================================================
  // Memory decode
  // ==========================================================================
  logic [4:0]           pg_lo_r;
  logic [4:0]           pg_hi_r;
  hmmd_pkg::hmmd_mem_t  dec_nxt;
  logic [4:0]           pg;
  logic [5:0]           pidx;
  logic [4:0]           pmax;
  logic                 sram_hit;

  // Map a window offset to a paged RAM address with wrap at the top.
  function automatic logic [20:0] page_map(input logic [4:0] page,
                                           input logic [16:0] off,
                                           input logic [4:0] maxp);
    logic [5:0] idx;
    idx = {1'b0, page} + {5'h00, off[16]};
    if (idx > {1'b0, maxp}) begin
      idx = 6'h00;
    end
    page_map = {idx[4:0], off[15:0]};
  endfunction

  // Select one region from the host address.
  always_comb begin
    dec_nxt = '0;
    pg = 5'h00;
    pidx = 6'h00;
    sram_hit = 1'b0;
    pmax = ram_exp ? `HMMD_PAGE_MAX_EXP : `HMMD_PAGE_MAX_BASE;
    if (mem_addr >= `HMMD_ROM_BASE) begin
      // Only upper half answers when 32K is fitted.
      if (rom_64k || mem_addr >= `HMMD_ROM_HALF) begin
        dec_nxt.sel = hmmd_pkg::HMMD_SEL_ROM;
        dec_nxt.addr = {5'h00, mem_addr[15:0]};
        dec_nxt.ready = 1'b1;
      end
    end else if (mem_addr >= `HMMD_SRAM_BASE) begin
      // Linear 8K block with aliasing above it.
      sram_hit = 1'b1;
      dec_nxt.sel = hmmd_pkg::HMMD_SEL_SRAM;
      dec_nxt.addr = {8'h00, mem_addr[12:0]};
    end else if (mem_addr > `HMMD_WIN_END) begin
      dec_nxt.sel = hmmd_pkg::HMMD_SEL_NONE;
    end else if (mem_addr > `HMMD_DRAM_END) begin
      // Two 128K windows, zero waits.
      pg = (mem_addr >= `HMMD_WIN_HI_BASE) ? pg_hi_r : pg_lo_r;
      dec_nxt.sel = hmmd_pkg::HMMD_SEL_PAGE;
      dec_nxt.addr = page_map(pg, mem_addr[16:0], pmax);
      dec_nxt.ready = 1'b1;
    end else begin
      dec_nxt.sel = hmmd_pkg::HMMD_SEL_DRAM;
      dec_nxt.addr = {1'b0, mem_addr};
      dec_nxt.ready = 1'b1;
    end
    if (!mem_req) begin
      dec_nxt = '0;
    end
  end

  // Shared SRAM request held until acknowledged; word cycles are dropped.
  logic sh_pend_r;
  logic sh_pend_nxt;
  logic sh_ack;
  logic sh_go;

  always_comb begin
    sh_go = mem_req && sram_hit && !mem_word;
    sh_pend_nxt = sh_go && !sh_ack;
  end

  // Register decode result; shared SRAM ready follows arbitration grant.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mem_dec   <= '0;
      sh_pend_r <= 1'b0;
    end else begin
      mem_dec   <= dec_nxt;
      sh_pend_r <= sh_pend_nxt;
      if (sram_hit && mem_req) begin
        mem_dec.ready <= sh_ack || (mem_word && mem_req);
      end
    end
  end

  hmmd_shared #(.AW(`HMMD_SRAM_AW)) u_shared (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .h_req   (sh_go),
    .h_we    (mem_we),
    .h_addr  (mem_addr[12:0]),
    .h_wdata (mem_wdata),
    .h_ack   (sh_ack),
    .s_req   (slp_sram_req),
    .s_we    (slp_sram_we),
    .s_addr  (slp_sram_addr),
    .s_wdata (slp_sram_wdata),
    .s_ack   (slp_sram_ack),
    .rdata   (sram_rdata)
  );

  // ==========================================================================
  // FIFO from slave line processor
  // ==========================================================================
  logic [FIFO_AW:0]   wp_r;
  logic [FIFO_AW:0]   wp_nxt;
  logic [FIFO_AW:0]   rp_r;
  logic [FIFO_AW:0]   rp_nxt;
  logic [7:0]         fifo_q;
  logic               f_empty;
  logic               f_full;
  logic               f_wr;
  logic               f_rd;
  logic               irq_nxt;
  logic               full_nxt;

  // Pointer update; reads of an empty FIFO are ignored.
  always_comb begin
    f_empty = (wp_r == rp_r);
    f_full  = (wp_r[FIFO_AW-1:0] == rp_r[FIFO_AW-1:0]) && (wp_r[FIFO_AW] != rp_r[FIFO_AW]);
    f_wr = slp_fifo_wr && !f_full;
    f_rd = io_rd && (io_addr == `HMMD_IO_FIFO) && !f_empty;
    wp_nxt = f_wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = f_rd ? rp_r + 1'b1 : rp_r;
    irq_nxt = (wp_nxt != rp_nxt);
    full_nxt = (wp_nxt[FIFO_AW-1:0] == rp_nxt[FIFO_AW-1:0]) &&
               (wp_nxt[FIFO_AW] != rp_nxt[FIFO_AW]);
  end

  // Register pointers and flags.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wp_r          <= '0;
      rp_r          <= '0;
      fifo_irq      <= 1'b0;
      slp_fifo_full <= 1'b0;
    end else begin
      wp_r          <= wp_nxt;
      rp_r          <= rp_nxt;
      fifo_irq      <= irq_nxt;
      slp_fifo_full <= full_nxt;
    end
  end

  hmmd_ram #(.AW(FIFO_AW), .DW(8)) u_fifo (
    .clk_sys (clk_sys),
    .we      (f_wr),
    .waddr   (wp_r[FIFO_AW-1:0]),
    .wdata   (slp_fifo_data),
    .raddr   (rp_r[FIFO_AW-1:0]),
    .rdata   (fifo_q)
  );

  // ==========================================================================
  // Panel switches, page register, program RAM load, I/O read
  // ==========================================================================
  logic [3:0]  sw_s1_r;
  logic [3:0]  sw_s2_r;
  logic [3:0]  sw_lat_r;
  logic [3:0]  sw_lat_nxt;
  logic [4:0]  pg_lo_nxt;
  logic [4:0]  pg_hi_nxt;
  logic        clr;
  logic        ps_we_nxt;
  logic [15:0] io_nxt;
  logic [PS_AW-1:0] ps_addr_nxt;
  logic [15:0] ps_wdata_nxt;

  // Latch closures; a closure in the clearing cycle still sets.
  always_comb begin
    clr = io_rd && (io_addr == `HMMD_IO_CLRPANEL);
    sw_lat_nxt = (clr ? 4'h0 : sw_lat_r) | sw_s2_r;
    pg_lo_nxt = pg_lo_r;
    pg_hi_nxt = pg_hi_r;
    if (io_wr && io_addr == `HMMD_IO_PAGE) begin
      pg_lo_nxt = io_wdata[4:0];
      pg_hi_nxt = io_wdata[`HMMD_PAGE_HI_LSB +: 5];
    end
    // Host writes slave program words through an address port.
    ps_addr_nxt = ps_addr;
    ps_wdata_nxt = ps_wdata;
    ps_we_nxt = 1'b0;
    if (io_wr && io_addr == `HMMD_IO_PSRAM) begin
      ps_addr_nxt = io_wdata[PS_AW-1:0];
    end
    if (ps_we) begin
      ps_addr_nxt = ps_addr + 1'b1;
    end
    if (io_wr && io_addr == `HMMD_IO_PSRAM + 16'h0010) begin
      ps_wdata_nxt = io_wdata;
      ps_we_nxt = 1'b1;
    end
    case (io_addr)
      `HMMD_IO_PAGE:     io_nxt = {3'h0, pg_hi_r, 3'h0, pg_lo_r};
      `HMMD_IO_SWITCHES: io_nxt = {12'h000, sw_lat_r};
      `HMMD_IO_CLRPANEL: io_nxt = {12'h000, sw_lat_r};
      default:           io_nxt = 16'h0000;
    endcase
  end

  // Register switch, page and load state; FIFO byte muxed after its read.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sw_s1_r  <= 4'h0;
      sw_s2_r  <= 4'h0;
      sw_lat_r <= 4'h0;
      pg_lo_r  <= 5'h00;
      pg_hi_r  <= 5'h00;
      ps_we    <= 1'b0;
      ps_addr  <= '0;
      ps_wdata <= 16'h0000;
      io_rdata <= 16'h0000;
    end else begin
      sw_s1_r  <= panel_sw;
      sw_s2_r  <= sw_s1_r;
      sw_lat_r <= sw_lat_nxt;
      pg_lo_r  <= pg_lo_nxt;
      pg_hi_r  <= pg_hi_nxt;
      ps_we    <= ps_we_nxt;
      ps_addr  <= ps_addr_nxt;
      ps_wdata <= ps_wdata_nxt;
      io_rdata <= (io_addr == `HMMD_IO_FIFO) ? {8'h00, fifo_q} : io_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- host_memory_map_decoder_tb.sv ----
// Self-checking bench for the host memory map decoder.
// Assumes hmmd_top, hmmd_host_bfm and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module host_memory_map_decoder_tb;
  logic                clk_sys, nrst, rom_64k, ram_exp, slp_fifo_wr, slp_fifo_full;
  logic                mem_req, mem_we, mem_word, io_rd, io_wr, fifo_irq, ps_we;
  logic [19:0]         mem_addr;
  logic [7:0]          mem_wdata, sram_rdata, slp_fifo_data, slp_sram_wdata;
  logic                slp_sram_req, slp_sram_we, slp_sram_ack;
  logic [12:0]         slp_sram_addr;
  logic [15:0]         io_addr, io_wdata, io_rdata, ps_wdata;
  logic [11:0]         ps_addr;
  logic [3:0]          panel_sw;
  hmmd_pkg::hmmd_mem_t mem_dec;
  int                  failures, n_compared;

  hmmd_top uut (.clk_sys, .nrst, .rom_64k, .ram_exp, .mem_req, .mem_we, .mem_word,
    .mem_addr, .mem_wdata, .mem_dec, .sram_rdata, .io_rd, .io_wr, .io_addr, .io_wdata,
    .io_rdata, .fifo_irq, .slp_fifo_wr, .slp_fifo_data, .slp_fifo_full,
    .slp_sram_req, .slp_sram_we, .slp_sram_addr,
    .slp_sram_wdata, .slp_sram_ack, .ps_we, .ps_addr, .ps_wdata, .panel_sw);

  hmmd_host_bfm bfm (.clk_sys, .mem_dec, .io_rdata, .mem_req, .mem_we, .mem_word,
    .mem_addr, .mem_wdata, .io_rd, .io_wr, .io_addr, .io_wdata);

  // ======================================
  // Clock, compares and verdict
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk_sel(input string n, input hmmd_pkg::hmmd_sel_t e,
                         input hmmd_pkg::hmmd_sel_t g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chk_val(input string n, input logic [20:0] e, input logic [20:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ======================================
  // Scenarios
  // One read cycle; the select and its completion are judged.
  task automatic dec1(input logic [19:0] a, input hmmd_pkg::hmmd_sel_t e);
    hmmd_pkg::hmmd_mem_t r;
    bfm.mem_cycle(a, 1'b0, 8'h00, r);
    chk_sel("mem_dec.sel", e, r.sel);
    chk_val("mem_dec.ready", 21'(e != hmmd_pkg::HMMD_SEL_NONE), 21'(r.ready));
  endtask

  task automatic t_decode();
    dec1(20'h00010, hmmd_pkg::HMMD_SEL_DRAM);
    dec1(20'h7ffff, hmmd_pkg::HMMD_SEL_DRAM);
    dec1(20'h80000, hmmd_pkg::HMMD_SEL_PAGE);
    dec1(20'hbffff, hmmd_pkg::HMMD_SEL_PAGE);
    dec1(20'hc0000, hmmd_pkg::HMMD_SEL_NONE);
    dec1(20'hdffff, hmmd_pkg::HMMD_SEL_NONE);
    dec1(20'hf8000, hmmd_pkg::HMMD_SEL_ROM);
    dec1(20'hf0000, hmmd_pkg::HMMD_SEL_NONE);
    rom_64k <= 1'b1;
    dec1(20'hf0000, hmmd_pkg::HMMD_SEL_ROM);
    dec1(20'hfffff, hmmd_pkg::HMMD_SEL_ROM);
  endtask

  // Writes the last alias byte and reads it back at the top of the linear block.
  task automatic t_sram();
    hmmd_pkg::hmmd_mem_t r;
    bfm.mem_cycle(20'heffff, 1'b1, 8'ha5, r);
    chk_val("alias ready", 21'h1, 21'(r.ready));
    bfm.mem_cycle(20'he1fff, 1'b0, 8'h00, r);
    chk_sel("sram sel", hmmd_pkg::HMMD_SEL_SRAM, r.sel);
    @(posedge clk_sys);
    chk_val("sram_rdata", 21'ha5, 21'(sram_rdata));
  endtask

  // The slave line processor writes a byte; the host then reads it back.
  task automatic t_slave();
    hmmd_pkg::hmmd_mem_t r;
    int                  i;
    @(posedge clk_sys);
    slp_sram_req   <= 1'b1;
    slp_sram_we    <= 1'b1;
    slp_sram_addr  <= 13'h0010;
    slp_sram_wdata <= 8'h5a;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      if (slp_sram_ack === 1'b1) break;
    end
    slp_sram_req <= 1'b0;
    chk_val("slp_sram_ack", 21'h1, 21'(slp_sram_ack));
    bfm.mem_cycle(20'he0010, 1'b0, 8'h00, r);
    @(posedge clk_sys);
    chk_val("sram_rdata", 21'h5a, 21'(sram_rdata));
  endtask

  task automatic pg(input logic [19:0] a, input logic [20:0] e);
    hmmd_pkg::hmmd_mem_t r;
    bfm.mem_cycle(a, 1'b0, 8'h00, r);
    chk_val("paged addr", e, r.addr);
  endtask

  task automatic t_page();
    logic [15:0] d;
    bfm.io_write(16'h2220, 16'h0503);
    bfm.io_read(16'h2220, d);
    chk_val("page reg", 21'h000503, 21'(d));
    pg(20'h80000, 21'h030000);
    pg(20'h90000, 21'h040000);
    pg(20'ha1234, 21'h051234);
    bfm.io_write(16'h2220, 16'h000f);
    pg(20'h90000, 21'h000000);
    ram_exp <= 1'b1;
    pg(20'h90000, 21'h100000);
    bfm.io_write(16'h2220, 16'h0017);
    pg(20'h90000, 21'h000000);
  endtask

  task automatic push(input logic [7:0] b);
    @(posedge clk_sys);
    slp_fifo_wr   <= 1'b1;
    slp_fifo_data <= b;
    @(posedge clk_sys);
    slp_fifo_wr   <= 1'b0;
  endtask

  // Fills past full, drains in order, then reads while empty.
  task automatic t_fifo();
    logic [15:0] d;
    int          i;
    for (i = 0; i < 64; i++) push(8'(i + 1));
    push(8'hee);
    repeat (2) @(posedge clk_sys);
    chk_val("slp_fifo_full", 21'h1, 21'(slp_fifo_full));
    chk_val("fifo_irq", 21'h1, 21'(fifo_irq));
    for (i = 0; i < 64; i++) begin
      bfm.io_read(16'h22c0, d);
      chk_val("fifo byte", 21'(i + 1), 21'(d[7:0]));
    end
    repeat (2) @(posedge clk_sys);
    chk_val("fifo_irq", 21'h0, 21'(fifo_irq));
    bfm.io_read(16'h22c0, d);
    push(8'h33);
    bfm.io_read(16'h22c0, d);
    chk_val("fifo byte", 21'h33, 21'(d[7:0]));
  endtask

  task automatic t_sw();
    logic [15:0] d;
    @(posedge clk_sys);
    panel_sw <= 4'h9;
    repeat (3) @(posedge clk_sys);
    panel_sw <= 4'h0;
    repeat (4) @(posedge clk_sys);
    bfm.io_read(16'h2248, d);
    chk_val("switch latch", 21'h9, 21'(d[3:0]));
    bfm.io_read(16'h2240, d);
    chk_val("switch clear read", 21'h9, 21'(d[3:0]));
    bfm.io_read(16'h2248, d);
    chk_val("switch latch", 21'h0, 21'(d[3:0]));
  endtask

  // Loads two program words at the last two addresses.
  task automatic t_ps();
    bfm.io_write(16'h22b0, 16'h0ffe);
    bfm.io_write(16'h22c0, 16'hbeef);
    @(posedge clk_sys);
    chk_val("ps_we", 21'h1, 21'(ps_we));
    chk_val("ps_addr", 21'hffe, 21'(ps_addr));
    chk_val("ps_wdata", 21'hbeef, 21'(ps_wdata));
    bfm.io_write(16'h22c0, 16'h1234);
    @(posedge clk_sys);
    chk_val("ps_addr", 21'hfff, 21'(ps_addr));
    chk_val("ps_wdata", 21'h1234, 21'(ps_wdata));
  endtask

  // ======================================
  // Main sequence and watchdog
  initial begin
    failures      = 0;
    n_compared    = 0;
    nrst          = 1'b0;
    rom_64k       = 1'b0;
    ram_exp       = 1'b0;
    slp_fifo_wr   = 1'b0;
    slp_fifo_data = 8'h00;
    panel_sw      = 4'h0;
    slp_sram_req  = 1'b0;
    slp_sram_we   = 1'b0;
    slp_sram_addr = 13'h0000;
    slp_sram_wdata = 8'h00;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    t_decode();
    t_sram();
    t_slave();
    t_page();
    t_fifo();
    t_sw();
    t_ps();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end
endmodule

`default_nettype wire
